// ==== logic/tsss_slave.sv ====
// SMBus slave, command decoder and registers of the thermal sensor
module tsss_slave #(
  parameter logic [6:0]  SLAVE_ADDR   = tsss_pkg::TSSS_SLAVE_ADDR_DEF,
  parameter logic [31:0] INTERVAL_CYC = 32'(tsss_pkg::TSSS_SLOWEST_PERIOD_CYC)
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // SMBus pins
  input  wire logic                   smb_clk,
  input  wire logic                   smb_dat_in,
  output logic                        smb_dat_out,
  output logic                        smb_dat_oe_n,
  // Alert pin
  output logic                        thermal_alert_n,
  // Converter front end
  input  wire tsss_pkg::tsss_sample_s sample,
  output logic                        conv_start,
  output logic                        conv_busy
);
  import tsss_pkg::*;

  // Pin synchronisers
  logic        clk_s1_ff;
  logic        clk_s2_ff;
  logic        clk_d_ff;
  logic        dat_s1_ff;
  logic        dat_s2_ff;
  logic        dat_d_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  // Bus engine
  tsss_state_e state_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  rx_sh_ff;
  logic [7:0]  tx_sh_ff;
  logic        oe_n_ff;
  logic        ack_on_ff;
  logic        rw_ff;
  logic        ara_ff;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;
  logic        last_bit;
  logic        addr_hit;
  logic        ara_hit;
  logic        cmd_take;
  logic        data_take;
  logic        read_done;
  logic        one_shot;

  // Registers
  logic [7:0]  cmd_ff;
  logic [7:0]  config_ff;
  logic [7:0]  rate_ff;
  logic [7:0]  high_limit_ff;
  logic [7:0]  low_limit_ff;
  logic [7:0]  temp_ff;
  logic        open_ff;
  logic        high_alarm_flag_ff;
  logic        low_alarm_flag_ff;
  logic        high_cond_ff;
  logic        low_cond_ff;
  logic        alert_n_ff;
  logic [7:0]  status;
  logic        high_cond;
  logic        low_cond;
  logic        status_clr;
  logic        ara_clr;
  logic        busy;

  // Two-stage synchronisers plus one delay stage for edges
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s1_ff <= 1'b1;
      clk_s2_ff <= 1'b1;
      clk_d_ff  <= 1'b1;
      dat_s1_ff <= 1'b1;
      dat_s2_ff <= 1'b1;
      dat_d_ff  <= 1'b1;
    end else begin
      clk_s1_ff <= smb_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_d_ff  <= clk_s2_ff;
      dat_s1_ff <= smb_dat_in;
      dat_s2_ff <= dat_s1_ff;
      dat_d_ff  <= dat_s2_ff;
    end
  end

  // Bus events and byte decode
  always_comb begin
    scl_rise  = clk_s2_ff && !clk_d_ff;
    scl_fall  = !clk_s2_ff && clk_d_ff;
    start_det = clk_s2_ff && clk_d_ff && dat_d_ff && !dat_s2_ff;
    stop_det  = clk_s2_ff && clk_d_ff && !dat_d_ff && dat_s2_ff;
    rx_byte   = {rx_sh_ff[6:0], dat_s2_ff};
    last_bit  = (bit_cnt_ff == TSSS_LAST_BIT);
    addr_hit  = (rx_byte[7:1] == SLAVE_ADDR);
    ara_hit   = (rx_byte[7:1] == TSSS_ARA_ADDR) && rx_byte[0] && !alert_n_ff;
    cmd_take  = scl_rise && (state_ff == TSSS_CMD) && last_bit;
    data_take = scl_rise && (state_ff == TSSS_DATA) && last_bit;
    read_done = scl_rise && (state_ff == TSSS_TX_ACK);
    one_shot  = cmd_take && (rx_byte == TSSS_SINGLE_CONVERSION_CMD);
  end

  // Read data selection
  always_comb begin
    tx_byte = 8'h00;
    if (ara_ff) begin
      tx_byte = {SLAVE_ADDR, 1'b1};
    end else begin
      unique case (cmd_ff)
        TSSS_READ_TEMP_CMD:       tx_byte = temp_ff;
        TSSS_READ_STATUS_CMD:     tx_byte = status;
        TSSS_READ_CONFIG_CMD:     tx_byte = config_ff;
        TSSS_READ_RATE_CMD:       tx_byte = rate_ff;
        TSSS_READ_HIGH_LIMIT_CMD: tx_byte = high_limit_ff;
        TSSS_READ_LOW_LIMIT_CMD:  tx_byte = low_limit_ff;
        default:                  tx_byte = 8'h00;
      endcase
    end
  end

  // Bus engine: bits in on clock rise, drive changes on clock fall
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff   <= TSSS_IDLE;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff   <= 8'h00;
      tx_sh_ff   <= 8'h00;
      oe_n_ff    <= 1'b1;
      ack_on_ff  <= 1'b0;
      rw_ff      <= 1'b0;
      ara_ff     <= 1'b0;
    end else if (start_det) begin
      state_ff   <= TSSS_ADDR;
      bit_cnt_ff <= 3'h0;
      oe_n_ff    <= 1'b1;
      ack_on_ff  <= 1'b0;
      ara_ff     <= 1'b0;
    end else if (stop_det) begin
      state_ff  <= TSSS_IDLE;
      oe_n_ff   <= 1'b1;
      ack_on_ff <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_ff)
        TSSS_ADDR: begin
          rx_sh_ff   <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (last_bit) begin
            rw_ff  <= rx_byte[0];
            ara_ff <= ara_hit;
            state_ff <= (addr_hit || ara_hit) ? TSSS_ADDR_ACK : TSSS_IDLE;
          end
        end
        TSSS_CMD: begin
          rx_sh_ff   <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (last_bit) begin
            state_ff <= TSSS_CMD_ACK;
          end
        end
        TSSS_DATA: begin
          rx_sh_ff   <= rx_byte;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (last_bit) begin
            state_ff <= TSSS_DATA_ACK;
          end
        end
        TSSS_TX: begin
          tx_sh_ff   <= {tx_sh_ff[6:0], 1'b0};
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (last_bit) begin
            state_ff <= TSSS_TX_ACK;
          end
        end
        TSSS_TX_ACK: begin
          bit_cnt_ff <= 3'h0;
          tx_sh_ff   <= tx_byte;
          state_ff   <= dat_s2_ff ? TSSS_IDLE : TSSS_TX;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_ff)
        TSSS_ADDR_ACK, TSSS_CMD_ACK, TSSS_DATA_ACK: begin
          if (!ack_on_ff) begin
            oe_n_ff   <= 1'b0;
            ack_on_ff <= 1'b1;
          end else begin
            ack_on_ff  <= 1'b0;
            bit_cnt_ff <= 3'h0;
            oe_n_ff    <= 1'b1;
            if (state_ff == TSSS_ADDR_ACK && rw_ff) begin
              state_ff <= TSSS_TX;
              tx_sh_ff <= tx_byte;
              oe_n_ff  <= tx_byte[7];
            end else if (state_ff == TSSS_ADDR_ACK) begin
              state_ff <= TSSS_CMD;
            end else if (state_ff == TSSS_CMD_ACK) begin
              state_ff <= TSSS_DATA;
            end else begin
              state_ff <= TSSS_IDLE;
            end
          end
        end
        TSSS_TX: begin
          oe_n_ff <= tx_sh_ff[7];
        end
        TSSS_TX_ACK: begin
          oe_n_ff <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Command pointer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ff <= TSSS_CMD_NONE;
    end else if (cmd_take) begin
      cmd_ff <= rx_byte;
    end
  end

  // Writable registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_ff     <= TSSS_CONFIG_RST;
      rate_ff       <= TSSS_RATE_RST;
      high_limit_ff <= TSSS_HIGH_LIMIT_RST;
      low_limit_ff  <= TSSS_LOW_LIMIT_RST;
    end else if (data_take) begin
      unique case (cmd_ff)
        TSSS_WRITE_CONFIG_CMD:     config_ff     <= rx_byte;
        TSSS_WRITE_RATE_CMD:       rate_ff       <= rx_byte;
        TSSS_WRITE_HIGH_LIMIT_CMD: high_limit_ff <= rx_byte;
        TSSS_WRITE_LOW_LIMIT_CMD:  low_limit_ff  <= rx_byte;
        default: begin
        end
      endcase
    end
  end

  // Conversion result
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_ff <= TSSS_TEMP_RST;
      open_ff <= 1'b0;
    end else if (sample.done) begin
      temp_ff <= sample.value;
      open_ff <= sample.open;
    end
  end

  // Alarm comparison against the new sample
  always_comb begin
    high_cond  = sample.done && ($signed(sample.value) >= $signed(high_limit_ff));
    low_cond   = sample.done && ($signed(sample.value) <= $signed(low_limit_ff));
    status_clr = read_done && !ara_ff && (cmd_ff == TSSS_READ_STATUS_CMD);
    ara_clr    = read_done && ara_ff;
    status = 8'h00;
    status[TSSS_ST_BUSY_BIT] = busy;
    status[TSSS_ST_HIGH_BIT] = high_alarm_flag_ff;
    status[TSSS_ST_LOW_BIT]  = low_alarm_flag_ff;
    status[TSSS_ST_OPEN_BIT] = open_ff;
  end

  // Sticky alarm flags; a new event wins over the read clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_alarm_flag_ff <= 1'b0;
      low_alarm_flag_ff  <= 1'b0;
      high_cond_ff       <= 1'b0;
      low_cond_ff        <= 1'b0;
    end else begin
      if (sample.done) begin
        high_cond_ff <= high_cond;
        low_cond_ff  <= low_cond;
      end
      high_alarm_flag_ff <= high_cond || (high_alarm_flag_ff && !(status_clr && !high_cond_ff));
      low_alarm_flag_ff  <= low_cond || (low_alarm_flag_ff && !(status_clr && !low_cond_ff));
    end
  end

  // Latched alert, released only by an alert response read
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_n_ff <= 1'b1;
    end else if (high_cond || low_cond) begin
      alert_n_ff <= 1'b0;
    end else if (ara_clr) begin
      alert_n_ff <= 1'b1;
    end
  end

  // Conversion scheduler
  tsss_conv #(
    .INTERVAL_CYC (INTERVAL_CYC)
  ) u_conv (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .standby    (config_ff[TSSS_CFG_STANDBY_BIT]),
    .rate_code  (rate_ff),
    .one_shot   (one_shot),
    .conv_done  (sample.done),
    .conv_start (conv_start),
    .conv_busy  (busy)
  );

  assign conv_busy       = busy;
  assign smb_dat_out     = 1'b0;
  assign smb_dat_oe_n    = oe_n_ff;
  assign thermal_alert_n = alert_n_ff;

endmodule : tsss_slave

// ==== include/tsss_pkg.sv ====
// Constants and types of the thermal sensor SMBus slave
package tsss_pkg;

  // Bus addresses
  localparam logic [6:0] TSSS_SLAVE_ADDR_DEF = 7'h4D;
  localparam logic [6:0] TSSS_ARA_ADDR       = 7'h0C;

  // Command codes
  localparam logic [7:0] TSSS_CMD_NONE             = 8'h00;
  localparam logic [7:0] TSSS_READ_TEMP_CMD        = 8'h01;
  localparam logic [7:0] TSSS_READ_STATUS_CMD      = 8'h02;
  localparam logic [7:0] TSSS_READ_CONFIG_CMD      = 8'h03;
  localparam logic [7:0] TSSS_READ_RATE_CMD        = 8'h04;
  localparam logic [7:0] TSSS_READ_HIGH_LIMIT_CMD  = 8'h07;
  localparam logic [7:0] TSSS_READ_LOW_LIMIT_CMD   = 8'h08;
  localparam logic [7:0] TSSS_WRITE_CONFIG_CMD     = 8'h09;
  localparam logic [7:0] TSSS_WRITE_RATE_CMD       = 8'h0A;
  localparam logic [7:0] TSSS_WRITE_HIGH_LIMIT_CMD = 8'h0D;
  localparam logic [7:0] TSSS_WRITE_LOW_LIMIT_CMD  = 8'h0E;
  localparam logic [7:0] TSSS_SINGLE_CONVERSION_CMD = 8'h0F;

  // Reset values
  localparam logic [7:0] TSSS_CONFIG_RST     = 8'h00;
  localparam logic [7:0] TSSS_RATE_RST       = 8'h02;
  localparam logic [7:0] TSSS_HIGH_LIMIT_RST = 8'h7F;
  localparam logic [7:0] TSSS_LOW_LIMIT_RST  = 8'hC9;
  localparam logic [7:0] TSSS_TEMP_RST       = 8'h00;

  // Field positions, highest rate code and last bit index
  localparam int TSSS_CFG_STANDBY_BIT = 6;
  localparam int TSSS_ST_BUSY_BIT     = 7;
  localparam int TSSS_ST_HIGH_BIT     = 4;
  localparam int TSSS_ST_LOW_BIT      = 3;
  localparam int TSSS_ST_OPEN_BIT     = 2;
  localparam logic [7:0] TSSS_RATE_MAX_CODE = 8'h07;
  localparam logic [2:0] TSSS_LAST_BIT      = 3'h7;

  // Timing: slowest conversion period is 16000 ms
  localparam int TSSS_CLK_PERIOD_NS      = 8;
  localparam int TSSS_SLOWEST_PERIOD_MS  = 16000;
  localparam logic [63:0] TSSS_SLOWEST_PERIOD_CYC =
    64'(TSSS_SLOWEST_PERIOD_MS) * 64'h00000000000F4240 / 64'(TSSS_CLK_PERIOD_NS);

  // Converter front end result
  typedef struct packed {
    logic       done;
    logic       open;
    logic [7:0] value;
  } tsss_sample_s;

  // Bus engine states
  typedef enum logic [8:0] {
    TSSS_IDLE     = 9'h001,
    TSSS_ADDR     = 9'h002,
    TSSS_ADDR_ACK = 9'h004,
    TSSS_CMD      = 9'h008,
    TSSS_CMD_ACK  = 9'h010,
    TSSS_DATA     = 9'h020,
    TSSS_DATA_ACK = 9'h040,
    TSSS_TX       = 9'h080,
    TSSS_TX_ACK   = 9'h100
  } tsss_state_e;

endpackage : tsss_pkg

// ==== logic/tsss_conv.sv ====
// Conversion scheduler: rate timer, one-shot and busy tracking
module tsss_conv #(
  parameter logic [31:0] INTERVAL_CYC = 32'(tsss_pkg::TSSS_SLOWEST_PERIOD_CYC)
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       standby,
  input  wire logic [7:0] rate_code,
  input  wire logic       one_shot,
  input  wire logic       conv_done,
  // Converter control
  output logic            conv_start,
  output logic            conv_busy
);
  import tsss_pkg::*;

  logic [31:0] timer_ff;
  logic [31:0] interval;
  logic [2:0]  code_eff;
  logic        busy_ff;
  logic        start_ff;
  logic        auto_due;
  logic        shot_ok;

  always_comb begin
    code_eff = (rate_code > TSSS_RATE_MAX_CODE) ? TSSS_RATE_MAX_CODE[2:0] : rate_code[2:0];
    interval = INTERVAL_CYC >> code_eff;
    auto_due = !standby && !busy_ff && (timer_ff == 32'h00000000);
    shot_ok  = one_shot && !busy_ff;
  end

  // Interval timer, zero at reset so the first conversion starts at once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_ff <= 32'h00000000;
    end else if (shot_ok || auto_due) begin
      timer_ff <= interval - 32'h00000001;
    end else if (standby) begin
      timer_ff <= interval - 32'h00000001;
    end else if (timer_ff != 32'h00000000) begin
      timer_ff <= timer_ff - 32'h00000001;
    end
  end

  // Busy flag and start pulse
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff  <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= shot_ok || auto_due;
      if (shot_ok || auto_due) begin
        busy_ff <= 1'b1;
      end else if (conv_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  assign conv_start = start_ff;
  assign conv_busy  = busy_ff;

endmodule : tsss_conv

// ==== logic/tsss_unused_placeholder_check.sv ====
// Empty compile-order note file is not needed

// ==== dv/tsss_slave_chk.sv ====
// Concurrent assertions on the ports of the thermal sensor SMBus slave
module tsss_slave_chk #(
  parameter logic [6:0]  SLAVE_ADDR   = tsss_pkg::TSSS_SLAVE_ADDR_DEF,
  parameter logic [31:0] INTERVAL_CYC = 32'(tsss_pkg::TSSS_SLOWEST_PERIOD_CYC)
) (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  // SMBus pins
  input wire logic                   smb_clk,
  input wire logic                   smb_dat_in,
  input wire logic                   smb_dat_out,
  input wire logic                   smb_dat_oe_n,
  // Alert and converter
  input wire logic                   thermal_alert_n,
  input wire tsss_pkg::tsss_sample_s sample,
  input wire logic                   conv_start,
  input wire logic                   conv_busy
);
  import tsss_pkg::*;
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_dat_out_low: assert property (smb_dat_out == 1'b0)
    else $error("data output value not low");
  a_drive_clk_low: assert property ($changed(smb_dat_oe_n) |-> !smb_clk)
    else $error("data drive changed while bus clock high");
  a_start_sets_busy: assert property (conv_start |-> conv_busy)
    else $error("start without busy");
  a_start_one_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_busy_no_start: assert property (conv_busy && !sample.done |=> !conv_start)
    else $error("start while converting");
  a_busy_holds: assert property (conv_busy && !sample.done |=> conv_busy)
    else $error("busy dropped before result");
  a_busy_ends: assert property (conv_busy && sample.done |=> !conv_busy)
    else $error("busy kept after result");
  a_alert_cause: assert property ($fell(thermal_alert_n) |-> $past(sample.done))
    else $error("alert without new result");
  a_alert_clear_bus: assert property (
    $rose(thermal_alert_n) |-> smb_clk && $past(smb_clk, 2))
    else $error("alert released outside bus clock high");
endmodule : tsss_slave_chk

// ==== dv/tsss_host.sv ====
// SMBus host model driving the sensor bus pins
module tsss_host (
  // Bus pins
  output logic      smb_clk,
  output logic      smb_dat_in,
  input  wire logic smb_dat_out,
  input  wire logic smb_dat_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25;
  logic sda_h = 1'b1;
  // Wired AND with pull-up
  assign smb_dat_in = sda_h & (smb_dat_oe_n | smb_dat_out);
  // Clock stands high outside frames
  initial smb_clk = 1'b1;

  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    #Q smb_clk = 1'b1;
    #Q r = smb_dat_in;
    #Q smb_clk = 1'b0;
    #Q;
  endtask : bit_io

  task automatic start_c();
    sda_h = 1'b1;
    #Q smb_clk = 1'b1;
    #Q sda_h = 1'b0;
    #Q smb_clk = 1'b0;
    #Q;
  endtask : start_c

  task automatic stop_c();
    sda_h = 1'b0;
    #Q smb_clk = 1'b1;
    #Q sda_h = 1'b1;
    #(4 * Q);
  endtask : stop_c

  task automatic tx(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask : tx

  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : rx

  // Write byte, or send byte when has_d is low
  task automatic write_t(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                         input bit has_d, output logic ok);
    ok = 1'b1;
    start_c();
    tx({a, 1'b0}, ok);
    tx(c, ok);
    if (has_d) begin
      tx(d, ok);
    end
    stop_c();
  endtask : write_t

  // Read byte, or receive byte when has_c is low
  task automatic read_t(input logic [6:0] a, input bit has_c, input logic [7:0] c,
                        output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start_c();
    if (has_c) begin
      tx({a, 1'b0}, ok);
      tx(c, ok);
      start_c();
    end
    tx({a, 1'b1}, ok);
    rx(d);
    stop_c();
  endtask : read_t
endmodule : tsss_host

// ==== dv/tsss_slave_bench.sv ====
// Self-checking testbench of the thermal sensor SMBus slave
module tsss_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tsss_pkg::*;
  localparam logic [31:0] IVL = 32'h000007D0;
  localparam logic [6:0]  ADR = TSSS_SLAVE_ADDR_DEF;
  logic         core_clk = 1'b0;
  logic         sys_rst  = 1'b1;
  logic         smb_clk, smb_dat_in, smb_dat_out, smb_dat_oe_n;
  logic         thermal_alert_n, conv_start, conv_busy, ok;
  logic [7:0]   temp = 8'h20;
  logic [7:0]   rd;
  logic [7:0]   rsv [5] = '{8'h05, 8'h06, 8'h0B, 8'h0C, 8'hC3};
  tsss_sample_s sample = '0;
  int           fails, n_tests, cyc, last_st, gap, n_st, n_dn, cnt;
  int           conv_lat = 40;
  integer       seed     = 32'heb927861;

`define CHK(nm, e, s) \
  n_tests++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, s); \
  end

  always #4 core_clk = ~core_clk;

  tsss_slave #(.SLAVE_ADDR(ADR), .INTERVAL_CYC(IVL)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .smb_clk(smb_clk), .smb_dat_in(smb_dat_in),
    .smb_dat_out(smb_dat_out), .smb_dat_oe_n(smb_dat_oe_n),
    .thermal_alert_n(thermal_alert_n), .sample(sample), .conv_start(conv_start),
    .conv_busy(conv_busy));
  tsss_host host (.smb_clk(smb_clk), .smb_dat_in(smb_dat_in), .smb_dat_out(smb_dat_out),
    .smb_dat_oe_n(smb_dat_oe_n));

  // Converter front end and start monitor
  always @(posedge core_clk) begin
    cyc    <= cyc + 1;
    cnt    <= (conv_start === 1'b1) ? conv_lat : (cnt > 0 ? cnt - 1 : 0);
    sample <= #1 '{done: cnt == 1, open: 1'b0, value: temp};
    n_dn   <= n_dn + int'(cnt == 1);
    if (conv_start === 1'b1) begin
      gap     <= cyc - last_st;
      last_st <= cyc;
      n_st    <= n_st + 1;
    end
  end

  function automatic bit in_win(int g, int e);
    return g >= e - 1 && g <= e + 1;
  endfunction : in_win

  function automatic logic [7:0] st_exp(logic [7:0] t, logic [7:0] h, logic [7:0] l);
    return {3'b000, $signed(t) >= $signed(h), $signed(t) <= $signed(l), 3'b000};
  endfunction : st_exp

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host.write_t(ADR, c, d, 1'b1, ok);
    `CHK("write ack", 1'b1, ok)
  endtask : wr

  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    host.read_t(ADR, 1'b1, c, rd, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK($sformatf("reg %0h", c), e & m, rd & m)
  endtask : rd_chk

  task automatic wait_ev(input bit on_start);
    int k0;
    k0 = on_start ? n_st : n_dn;
    for (int i = 0; i < 30000 && (on_start ? n_st : n_dn) == k0; i++) begin
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask : wait_ev

  task automatic alarm_case(input logic [7:0] t, input logic [7:0] h, input logic [7:0] l);
    temp = t;
    for (int i = 0; i < 2; i++) begin
      // Both limits, then neutral limits that only the extremes reach
      wr(TSSS_WRITE_HIGH_LIMIT_CMD, i == 0 ? h : 8'h7F);
      wr(TSSS_WRITE_LOW_LIMIT_CMD, i == 0 ? l : 8'h80);
      wait_ev(1'b0);
      wait_ev(1'b0);
      if (i == 0) begin
        // Flush flags left over from earlier limits
        host.read_t(ADR, 1'b1, TSSS_READ_STATUS_CMD, rd, ok);
        rd_chk(TSSS_READ_TEMP_CMD, t, 8'hFF);
        `CHK("alert set", 1'b0, thermal_alert_n)
      end
      // Flags persisted at the first read, so they still stand
      rd_chk(TSSS_READ_STATUS_CMD, st_exp(t, h, l), 8'h1C);
    end
    rd_chk(TSSS_READ_STATUS_CMD, st_exp(t, 8'h7F, 8'h80), 8'h1C);
    `CHK("alert latched", 1'b0, thermal_alert_n)
    // Quiet temperature so the alert cannot re-latch
    temp = 8'h00;
    wait_ev(1'b0);
    wait_ev(1'b0);
    host.read_t(TSSS_ARA_ADDR, 1'b0, 8'h00, rd, ok);
    `CHK("alert reply ack", 1'b1, ok)
    `CHK("alert reply byte", {ADR, 1'b1}, rd)
    `CHK("alert cleared", 1'b1, thermal_alert_n)
    host.read_t(TSSS_ARA_ADDR, 1'b0, 8'h00, rd, ok);
    `CHK("idle alert reply", 1'b0, ok)
  endtask : alarm_case

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog above the expected run of about 69000 cycles
  initial begin
    #(95000 * 8);
    fails++;
    test_done();
  end

  initial begin
    logic [7:0] cfg, rate, hi, lo;
    int         k;
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK("starts unprompted", 1, n_st)
    rd_chk(TSSS_READ_CONFIG_CMD, TSSS_CONFIG_RST, 8'hFF);
    rd_chk(TSSS_READ_RATE_CMD, TSSS_RATE_RST, 8'hFF);
    rd_chk(TSSS_READ_HIGH_LIMIT_CMD, TSSS_HIGH_LIMIT_RST, 8'hFF);
    rd_chk(TSSS_READ_LOW_LIMIT_CMD, TSSS_LOW_LIMIT_RST, 8'hFF);
    host.write_t(ADR ^ 7'h01, TSSS_WRITE_CONFIG_CMD, 8'h40, 1'b1, ok);
    `CHK("foreign address", 1'b0, ok)
    for (int i = 0; i < 5; i++) begin
      cfg  = 8'($random(seed)) & 8'h40;
      rate = 8'($random(seed)) & 8'h07;
      hi   = 8'($random(seed));
      lo   = 8'($random(seed));
      wr(TSSS_WRITE_CONFIG_CMD, cfg);
      wr(TSSS_WRITE_RATE_CMD, rate);
      wr(TSSS_WRITE_HIGH_LIMIT_CMD, hi);
      wr(TSSS_WRITE_LOW_LIMIT_CMD, lo);
      wr(rsv[i], 8'($random(seed)));
      rd_chk(TSSS_READ_CONFIG_CMD, cfg, 8'hFF);
      rd_chk(TSSS_READ_RATE_CMD, rate, 8'hFF);
      rd_chk(TSSS_READ_HIGH_LIMIT_CMD, hi, 8'hFF);
      rd_chk(TSSS_READ_LOW_LIMIT_CMD, lo, 8'hFF);
      host.read_t(ADR, 1'b0, 8'h00, rd, ok);
      `CHK("receive byte", lo, rd)
    end
    wr(TSSS_WRITE_CONFIG_CMD, 8'h00);
    wr(TSSS_WRITE_RATE_CMD, 8'h07);
    alarm_case(8'h7F, 8'h7F, 8'h80);
    temp = {2'b00, 6'($random(seed))} + 8'h10;
    alarm_case(temp, temp, 8'hC9);
    temp = 8'hC9;
    alarm_case(temp, 8'h7F, 8'hC9);
    conv_lat = 5;
    for (int c = 0; c < 9; c++) begin
      wr(TSSS_WRITE_RATE_CMD, c == 8 ? 8'h08 | 8'($random(seed)) : 8'(c));
      wait_ev(1'b1);
      wait_ev(1'b1);
      `CHK("rate gap", 1'b1, in_win(gap, int'(IVL >> (c == 8 ? 7 : c))))
    end
    conv_lat = 600;
    wr(TSSS_WRITE_RATE_CMD, 8'h00);
    wait_ev(1'b1);
    repeat (600 + 8'($random(seed))) @(posedge core_clk);
    k = n_st;
    host.write_t(ADR, TSSS_SINGLE_CONVERSION_CMD, 8'h00, 1'b0, ok);
    `CHK("one-shot start", k + 1, n_st)
    host.write_t(ADR, TSSS_SINGLE_CONVERSION_CMD, 8'h00, 1'b0, ok);
    `CHK("one-shot while busy", k + 1, n_st)
    wait_ev(1'b1);
    `CHK("interval restart", 1'b1, in_win(gap, int'(IVL)))
    wr(TSSS_WRITE_CONFIG_CMD, 8'h40);
    repeat (1500) @(posedge core_clk);
    k = n_st;
    repeat (1500) @(posedge core_clk);
    `CHK("standby quiet", k, n_st)
    host.write_t(ADR, TSSS_SINGLE_CONVERSION_CMD, 8'h00, 1'b0, ok);
    `CHK("send byte ack", 1'b1, ok)
    repeat (2500) @(posedge core_clk);
    `CHK("standby single", k + 1, n_st)
    test_done();
  end
endmodule : tsss_slave_bench

bind tsss_slave tsss_slave_chk #(.SLAVE_ADDR(SLAVE_ADDR), .INTERVAL_CYC(INTERVAL_CYC)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .smb_clk(smb_clk), .smb_dat_in(smb_dat_in),
  .smb_dat_out(smb_dat_out), .smb_dat_oe_n(smb_dat_oe_n),
  .thermal_alert_n(thermal_alert_n), .sample(sample), .conv_start(conv_start),
  .conv_busy(conv_busy));
